// File: shared/ecbx_pkg.sv
// Purpose: Shared constants and types for the chassis bus extender pair
// Assumes: Channel strobes are active-high levels synchronous to clk
// Notes: Port offsets are 10-bit I/O addresses on the host channel
package ecbx_pkg;

  // I/O port map of the extender card
  localparam logic [9:0] ECBX_PORT_EXT_DATA = 10'h210;
  localparam logic [9:0] ECBX_PORT_EXT_ADDR_HI = 10'h211;
  localparam logic [9:0] ECBX_PORT_EXT_ADDR_LO = 10'h212;
  localparam logic [9:0] ECBX_PORT_ENABLE_STATUS = 10'h213;

  // I/O port map of the receiver card
  localparam logic [9:0] ECBX_PORT_RCV_DATA = 10'h214;
  localparam logic [9:0] ECBX_PORT_RCV_ADDR_HI = 10'h215;
  localparam logic [9:0] ECBX_PORT_RCV_ADDR_LO = 10'h216;

  // Segment that never waits and that arms the address latches
  localparam logic [3:0] ECBX_TOP_SEGMENT = 4'hF;

  // Enable port commands and status layout
  localparam logic [7:0] ECBX_CMD_DISABLE = 8'h00;
  localparam logic [7:0] ECBX_CMD_ENABLE = 8'h01;
  localparam int ECBX_STAT_ENABLE_BIT = 0;
  localparam int ECBX_STAT_WAIT_BIT = 1;
  localparam int ECBX_STAT_SWITCH_LSB = 4;

  // Values after reset
  localparam logic ECBX_ENABLE_RESET = 1'b1;
  localparam logic [7:0] ECBX_DATA_RESET = 8'h00;
  localparam logic [15:0] ECBX_ADDR_RESET = 16'h0000;

  // Wait states added per chassis memory cycle
  localparam logic [1:0] ECBX_WAIT_STATES = 2'h1;

  // Host channel as seen by both cards
  typedef struct packed {
    logic [19:0] addr;
    logic memRead;
    logic memWrite;
    logic refresh;
    logic ioRead;
    logic ioWrite;
    logic aen;
    logic [7:0] data;
  } ecbx_chan_s;

  // Wait generator states, Gray along idle-wait-hold
  typedef enum logic [1:0] {
    ECBX_IDLE = 2'b00,
    ECBX_WAIT = 2'b01,
    ECBX_HOLD = 2'b11
  } ecbx_wait_e;

  // Extender state
  typedef struct packed {
    ecbx_wait_e waitState;
    logic [1:0] waitCnt;
    logic memRdPrev;
    logic memWrPrev;
    logic ioWrPrev;
    logic enable;
    logic waitFlag;
    logic [7:0] extData;
    logic [15:0] addrLatch;
    logic [7:0] readData;
    logic readOe;
    logic ready;
    logic memSelect_n;
    logic dirToHost;
  } ecbx_ext_s;

  // Receiver state
  typedef struct packed {
    logic memWrPrev;
    logic ioWrPrev;
    logic [7:0] rcvData;
    logic [15:0] addrLatch;
    logic steerToHost;
  } ecbx_rcv_s;

endpackage : ecbx_pkg

// File: design/ecbx_receiver.sv
// Purpose: Receiver card diagnostic latches and data direction steering
// Assumes: Channel inputs synchronous to clk; chassisHit decoded by the extender
// Notes: Latches are read back through the extender read mux
`timescale 1ns/100ps
module ecbx_receiver (
  input wire logic clk,
  input wire logic rst_n,
  input wire ecbx_pkg::ecbx_chan_s chan,
  input wire logic chassisEnable,
  input wire logic chassisHit,
  output logic [7:0] rcvData,
  output logic [15:0] rcvAddrLatch,
  output logic steerToHost
);
  import ecbx_pkg::*;

  ecbx_rcv_s q;
  ecbx_rcv_s d;
  logic memWrStart;
  logic ioWrStart;
  logic extPortHit;

  // Latch updates and steering decision
  always_comb begin
    d = q;
    memWrStart = chan.memWrite && !q.memWrPrev && !chan.refresh;
    ioWrStart = chan.ioWrite && !q.ioWrPrev && !chan.aen;
    extPortHit = (chan.addr[9:0] >= ECBX_PORT_EXT_DATA) &&
                 (chan.addr[9:0] <= ECBX_PORT_ENABLE_STATUS);
    d.memWrPrev = chan.memWrite;
    d.ioWrPrev = chan.ioWrite;
    // Only a live chassis sees the diagnostic write
    if (memWrStart && chassisEnable && chan.addr[19:16] == ECBX_TOP_SEGMENT) begin
      d.addrLatch = chan.addr[15:0];
    end
    if (ioWrStart && chan.addr[9:0] == ECBX_PORT_RCV_DATA) begin
      d.rcvData = chan.data;
    end
    // Drive toward host on chassis memory reads, enabled or not, and on I/O reads outside ports 210..213
    d.steerToHost = (chan.memRead && chassisHit) ||
                    (chan.ioRead && !chan.aen && !extPortHit);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{memWrPrev: 1'b0, ioWrPrev: 1'b0, rcvData: ECBX_DATA_RESET,
             addrLatch: ECBX_ADDR_RESET, steerToHost: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign rcvData = q.rcvData;
  assign rcvAddrLatch = q.addrLatch;
  assign steerToHost = q.steerToHost;

  property p_rcv_latch;
    @(posedge clk) disable iff (!rst_n)
    memWrStart && chassisEnable && chan.addr[19:16] == ECBX_TOP_SEGMENT
      |=> rcvAddrLatch == $past(chan.addr[15:0]);
  endproperty
  a_rcv_latch: assert property (p_rcv_latch) else $error("receiver address not latched");

  property p_rcv_data;
    @(posedge clk) disable iff (!rst_n)
    ioWrStart && chan.addr[9:0] == ECBX_PORT_RCV_DATA |=> rcvData == $past(chan.data);
  endproperty
  a_rcv_data: assert property (p_rcv_data) else $error("receiver data not latched");

endmodule : ecbx_receiver

// File: design/ecbx_extender.sv
// Purpose: Extender card wait-state generator, diagnostic ports and receiver pair
// Assumes: Host channel strobes are active-high levels synchronous to clk
// Notes: Reads answer one clock after the strobe is seen, held while it stays
`timescale 1ns/100ps

// Operation
// - One wait on chassis memory, not refresh
// - Switches 1..4 give address bits 19..16
// - Never wait in the top segment
// - Top-segment write latches address in extender
// - Ports 211/212 read latched address high/low
// - Port 210 writes and reads chassis data
// - Any write to 211 clears wait latch; a wait set in the same cycle wins
// - Port 213 write 00 disables, 01 enables
// - Port 213 reads enable D0, wait D1
// - Port 213 D7..D4 show switches, off=1
// - Chassis enabled after power-up
// - Enabled top write latches on both cards
// - Receiver port 214 latches and reads data
// - Receiver 215 high, 216 low address byte
// - Receiver steers extender buffer direction
// - Chassis memory cycle lasts five clocks
module ecbx_extender (
  input wire logic clk,
  input wire logic rst_n,
  input wire ecbx_pkg::ecbx_chan_s chan,
  input wire logic [3:0] switchOff,
  output logic channelReady,
  output logic chassisMemorySelect_n,
  output logic chassisEnable,
  output logic [7:0] chassisSideDataBits,
  output logic [7:0] readData,
  output logic readDataOe,
  output logic dataBufDirToHost
);
  import ecbx_pkg::*;

  ecbx_ext_s q;
  ecbx_ext_s d;
  logic [3:0] segLimit;
  logic chassisHit;
  logic topSegment;
  logic memStart;
  logic memWrStart;
  logic ioWrStart;
  logic ioRdActive;
  logic waitSet;
  logic waitClear;
  logic portHit;
  logic [7:0] portData;
  logic [7:0] rcvData;
  logic [15:0] rcvAddrLatch;
  logic rcvSteer;

  // Switch on means the bit is one in the memory limit
  assign segLimit = ~switchOff;
  assign topSegment = chan.addr[19:16] == ECBX_TOP_SEGMENT;
  // Memory at or above the system-unit limit, except the top segment, lives in the chassis
  assign chassisHit = (chan.addr[19:16] >= segLimit) && !topSegment;

  // The receiver sits across the cable but shares the channel view
  ecbx_receiver u_receiver (
    .clk(clk),
    .rst_n(rst_n),
    .chan(chan),
    .chassisEnable(q.enable),
    .chassisHit(chassisHit),
    .rcvData(rcvData),
    .rcvAddrLatch(rcvAddrLatch),
    .steerToHost(rcvSteer)
  );

  // Port read decode, shared by extender and receiver latches
  always_comb begin
    portHit = 1'b1;
    portData = 8'h00;
    case (chan.addr[9:0])
      ECBX_PORT_EXT_DATA: portData = q.extData;
      ECBX_PORT_EXT_ADDR_HI: portData = q.addrLatch[15:8];
      ECBX_PORT_EXT_ADDR_LO: portData = q.addrLatch[7:0];
      ECBX_PORT_ENABLE_STATUS: begin
        portData[ECBX_STAT_ENABLE_BIT] = q.enable;
        portData[ECBX_STAT_WAIT_BIT] = q.waitFlag;
        portData[ECBX_STAT_SWITCH_LSB +: 4] = switchOff;
      end
      ECBX_PORT_RCV_DATA: portData = rcvData;
      ECBX_PORT_RCV_ADDR_HI: portData = rcvAddrLatch[15:8];
      ECBX_PORT_RCV_ADDR_LO: portData = rcvAddrLatch[7:0];
      default: portHit = 1'b0;
    endcase
  end

  // Next-state logic for the whole extender
  always_comb begin
    d = q;
    memStart = ((chan.memRead && !q.memRdPrev) || (chan.memWrite && !q.memWrPrev))
               && !chan.refresh;
    memWrStart = chan.memWrite && !q.memWrPrev && !chan.refresh;
    ioWrStart = chan.ioWrite && !q.ioWrPrev && !chan.aen;
    ioRdActive = chan.ioRead && !chan.aen;
    // Refresh cycles are excluded; disabled chassis owns no memory
    waitSet = memStart && chassisHit && q.enable;
    waitClear = ioWrStart && chan.addr[9:0] == ECBX_PORT_EXT_ADDR_HI;
    d.memRdPrev = chan.memRead;
    d.memWrPrev = chan.memWrite;
    d.ioWrPrev = chan.ioWrite;

    // Wait generator: ready low for the wait count, then hold to strobe end
    case (q.waitState)
      ECBX_IDLE: begin
        d.ready = 1'b1;
        if (waitSet) begin
          d.ready = 1'b0;
          d.waitCnt = ECBX_WAIT_STATES;
          d.waitState = ECBX_WAIT;
        end
      end
      ECBX_WAIT: begin
        if (q.waitCnt == 2'h1) begin
          d.ready = 1'b1;
          d.waitState = ECBX_HOLD;
        end else begin
          d.waitCnt = q.waitCnt - 2'h1;
        end
      end
      ECBX_HOLD: begin
        d.ready = 1'b1;
        if (!chan.memRead && !chan.memWrite) begin
          d.waitState = ECBX_IDLE;
        end
      end
      default: begin
        d.ready = 1'b1;
        d.waitState = ECBX_IDLE;
      end
    endcase

    // Set wins over a clear in the same cycle so no wait is lost
    if (waitSet) begin
      d.waitFlag = 1'b1;
    end else if (waitClear) begin
      d.waitFlag = 1'b0;
    end

    // Top-segment writes latch regardless of the enable
    if (memWrStart && topSegment) begin
      d.addrLatch = chan.addr[15:0];
    end

    // Diagnostic port writes
    if (ioWrStart && chan.addr[9:0] == ECBX_PORT_EXT_DATA) begin
      d.extData = chan.data;
    end
    if (ioWrStart && chan.addr[9:0] == ECBX_PORT_ENABLE_STATUS) begin
      // Other values leave the enable as it was
      if (chan.data == ECBX_CMD_DISABLE) begin
        d.enable = 1'b0;
      end else if (chan.data == ECBX_CMD_ENABLE) begin
        d.enable = 1'b1;
      end
    end

    // Read data registered for the host; zero when nothing answers
    d.readOe = ioRdActive && portHit;
    d.readData = (ioRdActive && portHit) ? portData : 8'h00;

    // Chassis select follows a live memory cycle into the chassis
    d.memSelect_n = !((chan.memRead || chan.memWrite) && chassisHit && q.enable);
    // Buffer faces the host only when the receiver says so
    d.dirToHost = rcvSteer;
  end

  // State register; chassis comes up enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{waitState: ECBX_IDLE, waitCnt: 2'h0, memRdPrev: 1'b0, memWrPrev: 1'b0,
             ioWrPrev: 1'b0, enable: ECBX_ENABLE_RESET, waitFlag: 1'b0,
             extData: ECBX_DATA_RESET, addrLatch: ECBX_ADDR_RESET, readData: 8'h00,
             readOe: 1'b0, ready: 1'b1, memSelect_n: 1'b1, dirToHost: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign channelReady = q.ready;
  assign chassisMemorySelect_n = q.memSelect_n;
  assign chassisEnable = q.enable;
  assign chassisSideDataBits = q.extData;
  assign readData = q.readData;
  assign readDataOe = q.readOe;
  assign dataBufDirToHost = q.dirToHost;

  // Ready low for exactly one clock after a chassis cycle starts
  property p_wait_one;
    @(posedge clk) disable iff (!rst_n)
    waitSet |=> !channelReady ##1 channelReady;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("chassis wait not one clock");

  // Top segment never waits
  property p_no_top_wait;
    @(posedge clk) disable iff (!rst_n)
    memStart && topSegment && q.waitState == ECBX_IDLE |=> channelReady;
  endproperty
  a_no_top_wait: assert property (p_no_top_wait) else $error("wait in top segment");

  // Refresh never waits
  property p_no_refresh_wait;
    @(posedge clk) disable iff (!rst_n)
    chan.refresh && q.waitState == ECBX_IDLE |=> channelReady;
  endproperty
  a_no_refresh_wait: assert property (p_no_refresh_wait) else $error("wait on refresh");

  // Address latched on a top-segment write
  property p_addr_latch;
    @(posedge clk) disable iff (!rst_n)
    memWrStart && topSegment |=> q.addrLatch == $past(chan.addr[15:0]);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

  // High address byte read back
  property p_read_hi;
    @(posedge clk) disable iff (!rst_n)
    ioRdActive && chan.addr[9:0] == ECBX_PORT_EXT_ADDR_HI
      |=> readDataOe && readData == $past(q.addrLatch[15:8]);
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("bad high address read");

  // Data port write reaches the chassis side lines
  property p_data_write;
    @(posedge clk) disable iff (!rst_n)
    ioWrStart && chan.addr[9:0] == ECBX_PORT_EXT_DATA
      |=> chassisSideDataBits == $past(chan.data);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data port not latched");

  // Write to 211 clears the flag unless a new wait arrives
  property p_wait_clear;
    @(posedge clk) disable iff (!rst_n)
    waitClear && !waitSet |=> !q.waitFlag;
  endproperty
  a_wait_clear: assert property (p_wait_clear) else $error("wait flag not cleared");

  // Disable command turns the chassis off
  property p_enable_cmd;
    @(posedge clk) disable iff (!rst_n)
    ioWrStart && chan.addr[9:0] == ECBX_PORT_ENABLE_STATUS && chan.data == ECBX_CMD_DISABLE
      |=> !chassisEnable ##1 !chassisEnable;
  endproperty
  a_enable_cmd: assert property (p_enable_cmd) else $error("disable ignored");

  // Status layout
  property p_status;
    @(posedge clk) disable iff (!rst_n)
    ioRdActive && chan.addr[9:0] == ECBX_PORT_ENABLE_STATUS
      |=> readData == {$past(switchOff), 2'b00, $past(q.waitFlag), $past(q.enable)};
  endproperty
  a_status: assert property (p_status) else $error("bad status byte");

  // A wait always raises the flag
  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
    waitSet |=> q.waitFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("wait flag not set");

  // Receiver low address byte at its third port
  property p_rcv_lo;
    @(posedge clk) disable iff (!rst_n)
    ioRdActive && chan.addr[9:0] == ECBX_PORT_RCV_ADDR_LO
      |=> readData == $past(rcvAddrLatch[7:0]);
  endproperty
  a_rcv_lo: assert property (p_rcv_lo) else $error("bad receiver low read");

  // Low address byte read back
  property p_read_lo;
    @(posedge clk) disable iff (!rst_n)
    ioRdActive && chan.addr[9:0] == ECBX_PORT_EXT_ADDR_LO
      |=> readDataOe && readData == $past(q.addrLatch[7:0]);
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("bad low address read");

  // A live chassis memory strobe selects the chassis on the next clock
  property p_select;
    @(posedge clk) disable iff (!rst_n)
    (chan.memRead || chan.memWrite) && chassisHit && chassisEnable
      |=> !chassisMemorySelect_n;
  endproperty
  a_select: assert property (p_select) else $error("chassis not selected");

  // Buffer faces the host two clocks after a chassis memory read, through the receiver
  property p_dir_read;
    @(posedge clk) disable iff (!rst_n)
    chan.memRead && chassisHit |-> ##2 dataBufDirToHost;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("buffer not turned to host");

  c_chassis_wait: cover property (@(posedge clk) disable iff (!rst_n) waitSet);
  c_top_write: cover property (@(posedge clk) disable iff (!rst_n) memWrStart && topSegment);
  c_set_clear: cover property (@(posedge clk) disable iff (!rst_n) waitSet && waitClear);
  c_disable: cover property (@(posedge clk) disable iff (!rst_n) $fell(chassisEnable));

endmodule : ecbx_extender

// File: verif/ecbx_host_model.sv
// Purpose: Host channel model that runs memory and I/O cycles into the extender
// Assumes: Strobes change on the falling edge; memory strobes stretch while ready is low
// Notes: Released data lines show the inverse of the last byte, not a stale copy
`timescale 1ns/100ps
module ecbx_host_model (
  input wire logic clk,
  input wire logic channelReady,
  input wire logic chassisMemorySelect_n,
  input wire logic dataBufDirToHost,
  output ecbx_pkg::ecbx_chan_s chan
);
  import ecbx_pkg::*;

  // Idle channel; aen stays low until setAen marks a DMA cycle
  initial chan = '0;

  // Memory cycle: four clocks of strobe, one more for every clock that ready is low
  task automatic memCycle(input logic [19:0] a, input logic wr, input logic rf,
                          output int waits, output logic selLow, output logic dirHigh);
    int n;
    waits = 0;
    n = 0;
    selLow = 1'b0;
    dirHigh = 1'b0;
    @(negedge clk);
    chan.addr = a;
    chan.refresh = rf;
    chan.memWrite = wr;
    chan.memRead = !wr;
    // Bounded so a stuck ready cannot hang the model
    while (n < 4 + waits && n < 8) begin
      @(negedge clk);
      n++;
      if (channelReady === 1'b0) begin
        waits++;
      end
      if (chassisMemorySelect_n === 1'b0) begin
        selLow = 1'b1;
      end
      if (dataBufDirToHost === 1'b1) begin
        dirHigh = 1'b1;
      end
    end
    chan.memWrite = 1'b0;
    chan.memRead = 1'b0;
    chan.refresh = 1'b0;
  endtask : memCycle

  // I/O cycle: strobe held three clocks, answers are picked up by the bench monitor
  task automatic ioCycle(input logic [9:0] port, input logic wr, input logic [7:0] d);
    @(negedge clk);
    chan.addr = {10'h000, port};
    chan.data = d;
    chan.ioWrite = wr;
    chan.ioRead = !wr;
    repeat (3) @(negedge clk);
    chan.ioWrite = 1'b0;
    chan.ioRead = 1'b0;
    chan.data = ~d;
  endtask : ioCycle

  // DMA owns the channel while set, so I/O decode must ignore the cycle
  task automatic setAen(input logic v);
    chan.aen = v;
  endtask : setAen
endmodule : ecbx_host_model

// File: verif/expansion_chassis_bus_extender_tb.sv
// Purpose: Self-checking bench for the extender wait generator and diagnostic ports
// Assumes: Inputs change on the falling edge; reads are checked by a separate monitor
// Notes: Expected read bytes are queued by the driver and popped when an answer shows
`timescale 1ns/100ps
module expansion_chassis_bus_extender_tb;
  import ecbx_pkg::*;
  `define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin fails++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end

  logic clk = 1'b0;
  logic rst_n;
  ecbx_chan_s chan;
  logic [3:0] switchOff;
  logic channelReady;
  logic chassisMemorySelect_n;
  logic chassisEnable;
  logic [7:0] chassisSideDataBits;
  logic [7:0] readData;
  logic readDataOe;
  logic dataBufDirToHost;
  logic oePrev = 1'b0;
  logic [7:0] expByte;
  logic [7:0] expQ[$];
  logic [31:0] rng = 32'h1CD7D9F9;
  logic [15:0] extLatch = 16'h0000;
  logic [15:0] rcvLatch = 16'h0000;
  logic [3:0] seg;
  logic flag = 1'b0;
  logic expWait;
  logic expHit;
  logic selLow;
  logic dirHigh;
  int waits;
  int fails = 0;
  int cmpCount = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  ecbx_extender dut (
    .clk(clk), .rst_n(rst_n), .chan(chan), .switchOff(switchOff),
    .channelReady(channelReady), .chassisMemorySelect_n(chassisMemorySelect_n),
    .chassisEnable(chassisEnable), .chassisSideDataBits(chassisSideDataBits),
    .readData(readData), .readDataOe(readDataOe), .dataBufDirToHost(dataBufDirToHost)
  );

  ecbx_host_model host (
    .clk(clk), .channelReady(channelReady), .chassisMemorySelect_n(chassisMemorySelect_n),
    .dataBufDirToHost(dataBufDirToHost), .chan(chan)
  );

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nextRand

  // Queue the expected byte, then run the read cycle
  task automatic rd(input logic [9:0] port, input logic [7:0] exp);
    expQ.push_back(exp);
    host.ioCycle(port, 1'b0, 8'h00);
  endtask : rd

  task automatic wr(input logic [9:0] port, input logic [7:0] d);
    host.ioCycle(port, 1'b1, d);
  endtask : wr

  // Memory cycle with the expected wait count and latch tracking
  task automatic mem(input logic [19:0] a, input logic w, input logic rf, input logic en);
    host.memCycle(a, w, rf, waits, selLow, dirHigh);
    expHit = (a[19:16] >= ~switchOff) && (a[19:16] != ECBX_TOP_SEGMENT);
    expWait = !rf && en && expHit;
    `CHK(waits, expWait ? 1 : 0)
    `CHK(selLow, en && expHit)
    `CHK(dirHigh, !w && expHit)
    flag = flag | expWait;
    if (w && !rf && a[19:16] == ECBX_TOP_SEGMENT) begin
      extLatch = a[15:0];
      if (en) begin
        rcvLatch = a[15:0];
      end
    end
  endtask : mem

  task automatic end_of_test;
    `CHK(expQ.size(), 0)
    $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Monitor: each new read answer takes the oldest note; an answer with an empty queue is checked against XX
  always @(negedge clk) begin
    if (readDataOe === 1'b1 && oePrev !== 1'b1) begin
      expByte = (expQ.size() != 0) ? expQ.pop_front() : 8'hXX;
      `CHK(readData, expByte)
    end
    oePrev <= readDataOe;
  end

  // Hang guard, generous against the few hundred clocks the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      $display("Error at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    switchOff = 4'hF;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    `CHK(chassisEnable, 1'b1)
    rd(ECBX_PORT_ENABLE_STATUS, {switchOff, 4'b0001});
    $display("Test reset done");
    // Every other cycle sits right on the switch limit, where an off-by-one shows
    for (int i = 0; i < 32; i++) begin
      rng = nextRand(rng);
      switchOff = rng[3:0];
      seg = i[0] ? ~rng[3:0] : rng[7:4];
      mem({seg, rng[23:8]}, rng[24], rng[25] & rng[26], 1'b1);
    end
    rd(ECBX_PORT_ENABLE_STATUS, {switchOff, 2'b00, flag, 1'b1});
    switchOff = 4'hF;
    mem(20'h10000, 1'b0, 1'b0, 1'b1);
    rd(ECBX_PORT_ENABLE_STATUS, {switchOff, 2'b00, flag, 1'b1});
    wr(ECBX_PORT_EXT_ADDR_HI, rng[15:8]);
    flag = 1'b0;
    rd(ECBX_PORT_ENABLE_STATUS, {switchOff, 4'b0001});
    $display("Test wait generator done");
    mem(20'hF1234, 1'b1, 1'b0, 1'b1);
    rd(ECBX_PORT_EXT_ADDR_HI, 8'h12);
    rd(ECBX_PORT_EXT_ADDR_LO, 8'h34);
    rd(ECBX_PORT_RCV_ADDR_HI, 8'h12);
    rd(ECBX_PORT_RCV_ADDR_LO, 8'h34);
    $display("Test address latch done");
    wr(ECBX_PORT_ENABLE_STATUS, ECBX_CMD_DISABLE);
    `CHK(chassisEnable, 1'b0)
    wr(ECBX_PORT_ENABLE_STATUS, 8'h03);
    `CHK(chassisEnable, 1'b0)
    mem(20'h10000, 1'b0, 1'b0, 1'b0);
    mem(20'hF5678, 1'b1, 1'b0, 1'b0);
    rd(ECBX_PORT_EXT_ADDR_LO, extLatch[7:0]);
    rd(ECBX_PORT_RCV_ADDR_LO, rcvLatch[7:0]);
    rd(ECBX_PORT_ENABLE_STATUS, {switchOff, 4'b0000});
    wr(ECBX_PORT_ENABLE_STATUS, ECBX_CMD_ENABLE);
    `CHK(chassisEnable, 1'b1)
    host.setAen(1'b1);
    wr(ECBX_PORT_ENABLE_STATUS, ECBX_CMD_DISABLE);
    host.setAen(1'b0);
    `CHK(chassisEnable, 1'b1)
    $display("Test enable control done");
    rng = nextRand(rng);
    wr(ECBX_PORT_EXT_DATA, rng[7:0]);
    `CHK(chassisSideDataBits, rng[7:0])
    rd(ECBX_PORT_EXT_DATA, rng[7:0]);
    wr(ECBX_PORT_RCV_DATA, rng[15:8]);
    rd(ECBX_PORT_RCV_DATA, rng[15:8]);
    host.ioCycle(10'h217, 1'b0, 8'h00);
    `CHK(readDataOe, 1'b0)
    `CHK(dataBufDirToHost, 1'b1)
    $display("Test data latches done");
    end_of_test();
  end
endmodule : expansion_chassis_bus_extender_tb
